// >>> rtl/pml_consts.svh
`ifndef PML_CONSTS_SVH
`define PML_CONSTS_SVH
// ----------------------------------------------------------------
// clock and conversion timing
// ----------------------------------------------------------------
`define PML_CLK_MHZ          10
`define PML_CONV_TIME_US     50
`define PML_CONV_CYCLES      (`PML_CONV_TIME_US * `PML_CLK_MHZ)
// ----------------------------------------------------------------
// device register word indices
// ----------------------------------------------------------------
`define PML_DAW              4
`define PML_DA_CONFIG        4'h0
`define PML_DA_CUR_LIM       4'h1
`define PML_DA_VBUS_LIM      4'h2
`define PML_DA_POL           4'h3
`define PML_DA_CUR           4'h4
`define PML_DA_VBUS          4'h5
`define PML_DA_POW           4'h6
`define PML_DA_TEMP          4'h7
`define PML_DA_FAULT         4'h8
// ----------------------------------------------------------------
// device reset values and fields
// ----------------------------------------------------------------
`define PML_CONFIG_RST       32'h0000_0001
`define PML_CFG_RUN_BIT      0
`define PML_CUR_LIM_RST      16'h7fff
`define PML_VBUS_LIM_RST     16'h7fff
`define PML_POL_RST          16'hffff
`define PML_FLT_CUR          0
`define PML_FLT_VBUS         1
`define PML_FLT_POW          2
`define PML_NFLT             3
// ----------------------------------------------------------------
// result widths and limit scaling
// ----------------------------------------------------------------
`define PML_RES_W            20
`define PML_POW_W            24
`define PML_TEMP_W           16
`define PML_LIM_W            16
`define PML_LIM_STEPS        16
// ----------------------------------------------------------------
// result steps: current in nA, bus voltage in pV, power in uW,
// energy in uJ, temperature in n-degC
// ----------------------------------------------------------------
`define PML_CUR_LSB_NA       75000
`define PML_VBUS_LSB_PV      195312500
`define PML_POW_LSB_UW       240
`define PML_ENERGY_LSB_UJ    3840
`define PML_TEMP_LSB_NDEGC   7812500
`define PML_NA_PER_UA        1000
`define PML_PV_PER_UV        1000000
// ----------------------------------------------------------------
// host register byte offsets
// ----------------------------------------------------------------
`define PML_HA_CTRL          8'h00
`define PML_HA_ILIM          8'h04
`define PML_HA_VLIM          8'h08
`define PML_HA_PLIM          8'h0c
`define PML_HA_STAT          8'h10
`define PML_HA_CUR           8'h14
`define PML_HA_VBUS          8'h18
`define PML_HA_POW           8'h1c
`define PML_HA_TEMP          8'h20
`define PML_HA_FAULT         8'h24
`define PML_HA_IRQ_STAT      8'h28
`define PML_HA_IRQ_CLR       8'h2c
`define PML_HA_IRQ_EN        8'h30
`define PML_CTRL_PROG_BIT    0
`define PML_CTRL_CLR_BIT     1
`define PML_IRQ_DONE_BIT     3
`define PML_NIRQ             4
`define PML_ILIM_RST         32'd0
`define PML_VLIM_RST         32'd0
`define PML_PLIM_RST         32'h0000_ffff
// ----------------------------------------------------------------
// host link sequence steps
// ----------------------------------------------------------------
`define PML_STEP_W           4
`define PML_STEP_POLL        4'd4
`define PML_STEP_LAST        4'd8
`define PML_STEP_CLR         4'd9
`define PML_RESP_OKAY        2'b00
`define PML_RESP_SLVERR      2'b10
`endif

// >>> rtl/pml_pkg.sv
package pml_pkg;
`include "pml_consts.svh"

  typedef enum logic [2:0] {
    PH_TEMP = 3'b001,
    PH_CUR  = 3'b010,
    PH_VBUS = 3'b100
  } pml_phase_e;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_REQ  = 3'b010,
    HS_WAIT = 3'b100
  } pml_hstate_e;

  typedef struct packed {
    logic [31:0]               cfg;
    logic [`PML_LIM_W-1:0]     cur_lim;
    logic [`PML_LIM_W-1:0]     vbus_lim;
    logic [`PML_LIM_W-1:0]     pol;
    logic [`PML_RES_W-1:0]     cur;
    logic [`PML_RES_W-1:0]     vbus;
    logic [`PML_POW_W-1:0]     pow;
    logic [`PML_TEMP_W-1:0]    temp;
    logic [`PML_NFLT-1:0]      fault;
    pml_phase_e                phase;
    logic [15:0]               cnt;
    logic                      ack;
    logic [31:0]               rdata;
  } pml_dev_s;

  typedef struct packed {
    logic [31:0]               ilim;
    logic [31:0]               vlim;
    logic [31:0]               plim;
    logic [31:0]               cur;
    logic [31:0]               vbus;
    logic [31:0]               pow;
    logic [31:0]               temp;
    logic [`PML_NFLT-1:0]      fault;
    logic [`PML_NIRQ-1:0]      irq_stat;
    logic [`PML_NIRQ-1:0]      irq_en;
    logic                      prog_pend;
    logic                      clr_pend;
    logic                      busy;
    pml_hstate_e               st;
    logic [`PML_STEP_W-1:0]    step;
    logic                      req;
    logic                      we;
    logic [`PML_DAW-1:0]       addr;
    logic [31:0]               wdata;
    logic                      aw_held;
    logic [7:0]                awaddr;
    logic                      w_held;
    logic [31:0]               wdata_ax;
    logic [3:0]                wstrb;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
  } pml_host_s;
endpackage

// >>> rtl/pml_link_if.sv
`timescale 1ns/1ps
interface pml_link_if;
  logic                 req;
  logic                 we;
  logic [3:0]           addr;
  logic [31:0]          wdata;
  logic                 ack;
  logic [31:0]          rdata;
  logic                 alert;

  modport dev (
    input  req, we, addr, wdata,
    output ack, rdata, alert
  );
  modport host (
    output req, we, addr, wdata,
    input  ack, rdata, alert
  );
endinterface

// >>> rtl/pml_device.sv
`timescale 1ns/1ps
`include "pml_consts.svh"
module pml_device #(
  parameter int CONV_CYCLES = `PML_CONV_CYCLES
) (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // register link
  pml_link_if.dev                      lnk,
  // raw measurement inputs, already in result steps
  input  wire logic [`PML_TEMP_W-1:0]  die_temp,
  input  wire logic [`PML_RES_W-1:0]   shunt_cur,
  input  wire logic [`PML_RES_W-1:0]   bus_volt,
  input  wire logic [`PML_POW_W-1:0]   power_val,
  // status
  output logic [2:0]                   conv_phase,
  output logic [`PML_NFLT-1:0]         fault_flags
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pml_pkg::pml_dev_s st_r;
  pml_pkg::pml_dev_s st_nxt;

  logic                     run;
  logic                     conv_end;
  logic                     take;
  logic                     do_wr;
  logic                     cur_trip;
  logic                     vbus_trip;
  logic                     pow_trip;
  logic [`PML_NFLT-1:0]     trip;
  logic [`PML_NFLT-1:0]     clr;
  logic [31:0]              rd_mux;

  assign run      = st_r.cfg[`PML_CFG_RUN_BIT];
  assign conv_end = run && (st_r.cnt == 16'(CONV_CYCLES - 1));
  assign take     = lnk.req && !st_r.ack;
  assign do_wr    = take && lnk.we;

  // ----------------------------------------------------------------
  // limit comparison on the freshly taken sample
  // ----------------------------------------------------------------
  // upper result bits
  assign cur_trip  = $signed(shunt_cur[`PML_RES_W-1:`PML_RES_W-`PML_LIM_W])
                     > $signed(st_r.cur_lim);
  assign vbus_trip = $signed(bus_volt[`PML_RES_W-1:`PML_RES_W-`PML_LIM_W])
                     > $signed(st_r.vbus_lim);
  assign pow_trip  = power_val[`PML_POW_W-1:`PML_POW_W-`PML_LIM_W]
                     > st_r.pol;

  always_comb begin
    trip = '0;
    if (conv_end && st_r.phase == pml_pkg::PH_CUR) begin
      trip[`PML_FLT_CUR] = cur_trip;
    end
    if (conv_end && st_r.phase == pml_pkg::PH_VBUS) begin
      trip[`PML_FLT_VBUS] = vbus_trip;
      trip[`PML_FLT_POW]  = pow_trip;
    end
  end

  always_comb begin
    clr = '0;
    if (do_wr && lnk.addr == `PML_DA_FAULT) begin
      clr = lnk.wdata[`PML_NFLT-1:0];
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // sign extended results, power zero extended
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (lnk.addr)
      `PML_DA_CONFIG: rd_mux = st_r.cfg;
      `PML_DA_CUR_LIM:  rd_mux = {16'h0000, st_r.cur_lim};
      `PML_DA_VBUS_LIM: rd_mux = {16'h0000, st_r.vbus_lim};
      `PML_DA_POL:    rd_mux = {16'h0000, st_r.pol};
      `PML_DA_CUR:    rd_mux = {{(32-`PML_RES_W){st_r.cur[`PML_RES_W-1]}},
                                st_r.cur};
      `PML_DA_VBUS:   rd_mux = {{(32-`PML_RES_W){st_r.vbus[`PML_RES_W-1]}},
                                st_r.vbus};
      `PML_DA_POW:    rd_mux = {{(32-`PML_POW_W){1'b0}}, st_r.pow};
      `PML_DA_TEMP:   rd_mux = {{(32-`PML_TEMP_W){st_r.temp[`PML_TEMP_W-1]}},
                                st_r.temp};
      `PML_DA_FAULT:  rd_mux = {{(32-`PML_NFLT){1'b0}}, st_r.fault};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = take;
    if (take) begin
      st_nxt.rdata = rd_mux;
    end

    if (do_wr) begin
      unique case (lnk.addr)
        `PML_DA_CONFIG: st_nxt.cfg  = lnk.wdata;
        `PML_DA_CUR_LIM:  st_nxt.cur_lim  = lnk.wdata[`PML_LIM_W-1:0];
        `PML_DA_VBUS_LIM: st_nxt.vbus_lim = lnk.wdata[`PML_LIM_W-1:0];
        `PML_DA_POL:    st_nxt.pol  = lnk.wdata[`PML_LIM_W-1:0];
        default:        st_nxt.cfg  = st_r.cfg;
      endcase
    end

    if (run) begin
      st_nxt.cnt = conv_end ? 16'h0000 : st_r.cnt + 16'h0001;
    end else begin
      st_nxt.cnt = 16'h0000;
    end

    if (conv_end) begin
      unique case (st_r.phase)
        pml_pkg::PH_TEMP: begin
          st_nxt.temp  = die_temp;
          st_nxt.phase = pml_pkg::PH_CUR;
        end
        pml_pkg::PH_CUR: begin
          st_nxt.cur   = shunt_cur;
          st_nxt.phase = pml_pkg::PH_VBUS;
        end
        pml_pkg::PH_VBUS: begin
          st_nxt.vbus  = bus_volt;
          st_nxt.pow   = power_val;
          st_nxt.phase = pml_pkg::PH_TEMP;
        end
      endcase
    end

    // sticky flags, a new trip beats a clear
    st_nxt.fault = (st_r.fault & ~clr) | trip;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // defaults at every power-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r.cfg   <= `PML_CONFIG_RST;
      st_r.cur_lim  <= `PML_CUR_LIM_RST;
      st_r.vbus_lim <= `PML_VBUS_LIM_RST;
      st_r.pol   <= `PML_POL_RST;
      st_r.cur   <= '0;
      st_r.vbus  <= '0;
      st_r.pow   <= '0;
      st_r.temp  <= '0;
      st_r.fault <= '0;
      st_r.phase <= pml_pkg::PH_TEMP;
      st_r.cnt   <= 16'h0000;
      st_r.ack   <= 1'b0;
      st_r.rdata <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign lnk.ack     = st_r.ack;
  assign lnk.rdata   = st_r.rdata;
  assign lnk.alert   = |st_r.fault;
  assign conv_phase  = st_r.phase;
  assign fault_flags = st_r.fault;

endmodule // pml_device

// >>> rtl/pml_host.sv
`timescale 1ns/1ps
`include "pml_consts.svh"
module pml_host (
  // clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // axi4-lite write
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  // interrupt
  output logic                 irq,
  // device link
  pml_link_if.host             lnk
);

  pml_pkg::pml_host_s h_r;
  pml_pkg::pml_host_s h_nxt;

  logic        wr_go;
  logic        rd_go;
  logic [31:0] wval;
  logic [31:0] rval;
  logic        rbad;
  logic        wbad;
  logic [63:0] ilim_code;
  logic [63:0] vlim_code;
  logic [3:0]  ev;

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // limit code conversion
  // ----------------------------------------------------------------
  // current over 16 steps
  assign ilim_code = (64'(h_r.ilim) * 64'(`PML_NA_PER_UA))
                     / 64'(`PML_CUR_LSB_NA * `PML_LIM_STEPS);
  assign vlim_code = (64'(h_r.vlim) * 64'(`PML_PV_PER_UV))
                     / (64'(`PML_VBUS_LSB_PV) * 64'(`PML_LIM_STEPS));

  // ----------------------------------------------------------------
  // axi decode
  // ----------------------------------------------------------------
  assign wr_go = h_r.aw_held && h_r.w_held && !h_r.bvalid;
  assign rd_go = s_axi_arvalid && !h_r.rvalid;

  always_comb begin
    wval = 32'h0000_0000;
    wbad = 1'b0;
    unique case (h_r.awaddr)
      `PML_HA_ILIM:    wval = merge(h_r.ilim, h_r.wdata_ax, h_r.wstrb);
      `PML_HA_VLIM:    wval = merge(h_r.vlim, h_r.wdata_ax, h_r.wstrb);
      `PML_HA_PLIM:    wval = merge(h_r.plim, h_r.wdata_ax, h_r.wstrb);
      `PML_HA_CTRL,
      `PML_HA_IRQ_CLR,
      `PML_HA_IRQ_EN:  wval = merge(32'h0, h_r.wdata_ax, h_r.wstrb);
      default:         wbad = 1'b1;
    endcase
  end

  always_comb begin
    rval = 32'h0000_0000;
    rbad = 1'b0;
    unique case (s_axi_araddr)
      `PML_HA_CTRL,
      `PML_HA_IRQ_CLR: rval = 32'h0000_0000;
      `PML_HA_ILIM:    rval = h_r.ilim;
      `PML_HA_VLIM:    rval = h_r.vlim;
      `PML_HA_PLIM:    rval = h_r.plim;
      `PML_HA_STAT:    rval = {31'h0, h_r.busy};
      `PML_HA_CUR:     rval = h_r.cur;
      `PML_HA_VBUS:    rval = h_r.vbus;
      `PML_HA_POW:     rval = h_r.pow;
      `PML_HA_TEMP:    rval = h_r.temp;
      `PML_HA_FAULT:   rval = {29'h0, h_r.fault};
      `PML_HA_IRQ_STAT: rval = {28'h0, h_r.irq_stat};
      `PML_HA_IRQ_EN:  rval = {28'h0, h_r.irq_en};
      default:         rbad = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    h_nxt = h_r;
    ev = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      h_nxt.aw_held = 1'b1;
      h_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      h_nxt.w_held   = 1'b1;
      h_nxt.wdata_ax = s_axi_wdata;
      h_nxt.wstrb    = s_axi_wstrb;
    end
    if (h_r.bvalid && s_axi_bready) h_nxt.bvalid = 1'b0;
    if (wr_go) begin
      h_nxt.aw_held = 1'b0;
      h_nxt.w_held  = 1'b0;
      h_nxt.bvalid  = 1'b1;
      h_nxt.bresp   = wbad ? `PML_RESP_SLVERR : `PML_RESP_OKAY;
      unique case (h_r.awaddr)
        `PML_HA_ILIM:  h_nxt.ilim = wval;
        `PML_HA_VLIM:  h_nxt.vlim = wval;
        `PML_HA_PLIM:  h_nxt.plim = wval;
        `PML_HA_IRQ_EN: h_nxt.irq_en = wval[`PML_NIRQ-1:0];
        `PML_HA_CTRL: begin
          if (wval[`PML_CTRL_PROG_BIT]) h_nxt.prog_pend = 1'b1;
          if (wval[`PML_CTRL_CLR_BIT])  h_nxt.clr_pend  = 1'b1;
        end
        default: h_nxt.ilim = h_r.ilim;
      endcase
    end
    if (h_r.rvalid && s_axi_rready) h_nxt.rvalid = 1'b0;
    if (rd_go) begin
      h_nxt.rvalid = 1'b1;
      h_nxt.rdata  = rval;
      h_nxt.rresp  = rbad ? `PML_RESP_SLVERR : `PML_RESP_OKAY;
    end

    // link sequencer: program, then poll, going back to program or to a fault clear when one is pending
    unique case (h_r.st)
      pml_pkg::HS_IDLE: begin
        h_nxt.st = pml_pkg::HS_REQ;
      end
      pml_pkg::HS_REQ: begin
        h_nxt.req = 1'b1;
        h_nxt.we  = (h_r.step < `PML_STEP_POLL) ||
                    (h_r.step == `PML_STEP_CLR);
        unique case (h_r.step)
          4'd0: begin
            h_nxt.addr  = `PML_DA_CONFIG;
            h_nxt.wdata = `PML_CONFIG_RST;
          end
          4'd1: begin
            h_nxt.addr  = `PML_DA_CUR_LIM;
            h_nxt.wdata = {16'h0, ilim_code[15:0]};
          end
          4'd2: begin
            h_nxt.addr  = `PML_DA_VBUS_LIM;
            h_nxt.wdata = {16'h0, vlim_code[15:0]};
          end
          4'd3: begin
            h_nxt.addr  = `PML_DA_POL;
            h_nxt.wdata = {16'h0, h_r.plim[15:0]};
          end
          4'd4: h_nxt.addr = `PML_DA_CUR;
          4'd5: h_nxt.addr = `PML_DA_VBUS;
          4'd6: h_nxt.addr = `PML_DA_POW;
          4'd7: h_nxt.addr = `PML_DA_TEMP;
          4'd8: h_nxt.addr = `PML_DA_FAULT;
          default: begin
            h_nxt.addr  = `PML_DA_FAULT;
            h_nxt.wdata = {29'h0, {`PML_NFLT{1'b1}}};
          end
        endcase
        h_nxt.st = pml_pkg::HS_WAIT;
      end
      pml_pkg::HS_WAIT: begin
        if (lnk.ack) begin
          h_nxt.req = 1'b0;
          h_nxt.st  = pml_pkg::HS_REQ;
          unique case (h_r.step)
            4'd4: h_nxt.cur  = lnk.rdata;
            4'd5: h_nxt.vbus = lnk.rdata;
            4'd6: h_nxt.pow  = lnk.rdata;
            4'd7: h_nxt.temp = lnk.rdata;
            4'd8: begin
              h_nxt.fault = lnk.rdata[`PML_NFLT-1:0];
              ev[`PML_NFLT-1:0] = lnk.rdata[`PML_NFLT-1:0] & ~h_r.fault;
            end
            default: h_nxt.cur = h_r.cur;
          endcase
          if (h_r.step == 4'd3) begin
            h_nxt.busy = 1'b0;
            ev[`PML_IRQ_DONE_BIT] = 1'b1;
          end
          h_nxt.step = h_r.step + 4'd1;
          if (h_r.step == `PML_STEP_LAST || h_r.step == `PML_STEP_CLR) begin
            if (h_r.prog_pend) begin
              h_nxt.step      = 4'd0;
              h_nxt.prog_pend = 1'b0;
              h_nxt.busy      = 1'b1;
            end else if (h_r.clr_pend) begin
              h_nxt.step     = `PML_STEP_CLR;
              h_nxt.clr_pend = 1'b0;
            end else begin
              h_nxt.step = `PML_STEP_POLL;
            end
          end
        end
      end
    endcase

    // set beats clear
    if (wr_go && h_r.awaddr == `PML_HA_IRQ_CLR) begin
      h_nxt.irq_stat = h_r.irq_stat & ~wval[`PML_NIRQ-1:0];
    end
    h_nxt.irq_stat = h_nxt.irq_stat | ev;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      h_r           <= '0;
      h_r.ilim      <= `PML_ILIM_RST;
      h_r.vlim      <= `PML_VLIM_RST;
      h_r.plim      <= `PML_PLIM_RST;
      h_r.busy      <= 1'b1;
      h_r.st        <= pml_pkg::HS_IDLE;
      h_r.step      <= 4'd0;
    end else begin
      h_r <= h_nxt;
    end
  end

  assign s_axi_awready = !h_r.aw_held && !h_r.bvalid;
  assign s_axi_wready  = !h_r.w_held && !h_r.bvalid;
  assign s_axi_bvalid  = h_r.bvalid;
  assign s_axi_bresp   = h_r.bresp;
  assign s_axi_arready = !h_r.rvalid;
  assign s_axi_rvalid  = h_r.rvalid;
  assign s_axi_rdata   = h_r.rdata;
  assign s_axi_rresp   = h_r.rresp;
  assign irq           = |(h_r.irq_stat & h_r.irq_en);
  assign lnk.req       = h_r.req;
  assign lnk.we        = h_r.we;
  assign lnk.addr      = h_r.addr;
  assign lnk.wdata     = h_r.wdata;

endmodule // pml_host

// >>> dv/pml_props.sv
`timescale 1ns/1ps
`include "pml_consts.svh"
module pml_props (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // device link
  input wire logic        req,
  input wire logic        we,
  input wire logic [3:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        ack,
  input wire logic [31:0] rdata,
  input wire logic        alert
);
  // ------------
  // link checks
  // ------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_cfg;
    req && we && addr == `PML_DA_CONFIG && wdata == `PML_CONFIG_RST;
  endsequence
  sequence s_clr;
    ack && $past(req && we && addr == `PML_DA_FAULT);
  endsequence
  property p_cfg; $rose(aresetn) |-> ##[0:4] s_cfg; endproperty
  property p_pulse; ack |=> !ack; endproperty
  property p_answer; $rose(req) |=> ack; endproperty
  property p_hold;
    req && !ack |=> req && $stable(addr) && $stable(wdata) && $stable(we);
  endproperty
  property p_drop; ack |=> !req; endproperty
  property p_cause; ack |-> $past(req); endproperty
  property p_lim;
    req && we && addr == `PML_DA_CUR_LIM |-> wdata[31:16] == 16'h0000;
  endproperty
  // faults fall only through a clear write
  property p_sticky; $fell(alert) |-> s_clr; endproperty
  a_cfg: assert property (p_cfg) else $error("no config write");
  a_pulse: assert property (p_pulse) else $error("ack too long");
  a_answer: assert property (p_answer) else $error("ack late");
  a_hold: assert property (p_hold) else $error("request moved");
  a_drop: assert property (p_drop) else $error("req not dropped");
  a_cause: assert property (p_cause) else $error("stray ack");
  a_lim: assert property (p_lim) else $error("limit too wide");
  a_sticky: assert property (p_sticky) else $error("fault lost");
endmodule // pml_props

// >>> dv/tb_power_monitor_limits_readout.sv
`timescale 1ns/1ps
`include "pml_consts.svh"
module tb_power_monitor_limits_readout;
  localparam longint IL = 64'd16 * `PML_CUR_LSB_NA / `PML_NA_PER_UA * 100;
  localparam longint VL = 64'd16 * `PML_VBUS_LSB_PV / `PML_PV_PER_UV * 50;
  logic        aclk = 1'b0, aresetn = 1'b0, quiet = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, lfsr = 32'ha643efdf, last, rdata, rnd;
  logic [15:0] die_temp = 16'h0;
  logic [19:0] shunt_cur = 20'h0, bus_volt = 20'h0;
  logic [23:0] power_val = 24'h0;
  logic [2:0]  phase, flags, prev = 3'b001;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          errors = 0, check_count = 0;
  pml_link_if lnk ();
  pml_device #(.CONV_CYCLES(4)) u_pml_device (.aclk(aclk),
    .aresetn(aresetn), .lnk(lnk), .die_temp(die_temp),
    .shunt_cur(shunt_cur), .bus_volt(bus_volt), .power_val(power_val),
    .conv_phase(phase), .fault_flags(flags));
  pml_host u_pml_host (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .lnk(lnk));
  pml_props u_pml_props (.aclk(aclk), .aresetn(aresetn), .req(lnk.req),
    .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack),
    .rdata(lnk.rdata), .alert(lnk.alert));
  always #50 aclk = ~aclk;
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge aclk) begin
    lfsr <= nx(lfsr);
    die_temp <= lfsr[15:0];
    if (bvalid && bready) cmp(bresp, bq.pop_front());
    if (rvalid && rready && !quiet) cmp({rresp, rdata}, rq.pop_front());
    if (!aresetn) prev <= 3'b001;
    else if (phase !== prev) begin
      cmp(phase, {prev[1:0], prev[2]});
      prev <= phase;
    end
  end
  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge aclk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e,
                    input logic q);
    @(posedge aclk);
    quiet = q;
    if (!q) rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    last = rdata;
    rready <= 1'b0;
  endtask
  // polls, up to 60 reads, until the mirror shows the expected value, then one checked read
  task automatic look(input logic [7:0] a, input logic [33:0] e);
    last = ~e[31:0];
    for (int n = 0; n < 60 && last !== e[31:0]; n++) rd(a, e, 1'b1);
    rd(a, e, 1'b0);
  endtask
  task automatic rst;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    look(`PML_HA_STAT, 34'h0);
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #(100 * 40000);
    errors++;
    test_done();
  end
  initial begin
    rst();
    wr(`PML_HA_ILIM, 32'(IL), `PML_RESP_OKAY);
    wr(`PML_HA_VLIM, 32'(VL), `PML_RESP_OKAY);
    wr(`PML_HA_PLIM, 32'h7, `PML_RESP_OKAY);
    wr(`PML_HA_IRQ_CLR, 32'hf, `PML_RESP_OKAY);
    wr(`PML_HA_CTRL, 32'h1, `PML_RESP_OKAY);
    look(`PML_HA_IRQ_STAT, 34'h8);
    shunt_cur <= {16'd100, 4'hf};
    bus_volt <= {16'd50, 4'hf};
    power_val <= {16'd7, 8'hff};
    look(`PML_HA_POW, 34'h7ff);
    look(`PML_HA_CUR, 34'h64f);
    shunt_cur <= 20'hfffff;
    bus_volt <= 20'h80000;
    look(`PML_HA_CUR, 34'hffffffff);
    look(`PML_HA_VBUS, 34'hfff80000);
    repeat (3) @(posedge phase[0]);
    look(`PML_HA_FAULT, 34'h0);
    shunt_cur <= {16'd101, 4'h0};
    bus_volt <= {16'd51, 4'h0};
    power_val <= {16'd8, 8'h00};
    look(`PML_HA_FAULT, 34'h7);
    cmp(flags, 34'h7);
    cmp(irq, 34'h0);
    look(`PML_HA_IRQ_STAT, 34'hf);
    wr(`PML_HA_IRQ_EN, 32'hf, `PML_RESP_OKAY);
    @(posedge aclk);
    cmp(irq, 34'h1);
    wr(`PML_HA_IRQ_CLR, 32'hf, `PML_RESP_OKAY);
    @(posedge aclk);
    cmp(irq, 34'h0);
    shunt_cur <= 20'h0;
    bus_volt <= 20'h0;
    power_val <= 24'h0;
    repeat (3) @(posedge phase[0]);
    look(`PML_HA_FAULT, 34'h7);
    wr(`PML_HA_CTRL, 32'h2, `PML_RESP_OKAY);
    look(`PML_HA_FAULT, 34'h0);
    rnd = lfsr;
    wr(`PML_HA_ILIM, rnd, `PML_RESP_OKAY);
    look(`PML_HA_ILIM, {2'b00, rnd});
    wr(8'h3c, rnd, `PML_RESP_SLVERR);
    look(8'h3c, {`PML_RESP_SLVERR, 32'h0});
    rst();
    look(`PML_HA_ILIM, 34'h0);
    look(`PML_HA_VLIM, 34'h0);
    look(`PML_HA_PLIM, 34'hffff);
    look(`PML_HA_IRQ_EN, 34'h0);
    test_done();
  end
endmodule // tb_power_monitor_limits_readout
